// file: anss_map.svh
// Purpose: Timing constants for the host side of the sleep-capable async memory port
// Assumes: 100 MHz controller clock, device run in its upper supply range
// Notes: Every cycle count except ANSS_SYNC_CYC is rounded up from a time converted to nanoseconds
`ifndef ANSS_MAP_SVH
`define ANSS_MAP_SVH

`define ANSS_CLK_NS 10
`define ANSS_T_AA_NS 90
`define ANSS_T_AAP_NS 30
`define ANSS_T_PC_NS 30
`define ANSS_T_WP_NS 18
`define ANSS_T_CW_NS 60
`define ANSS_T_ZZL_US 1
`define ANSS_T_ZZEX_US 450
`define ANSS_T_PU_MS 1
`define ANSS_SYNC_CYC 2

`define ANSS_CEIL(ns) (((ns) + `ANSS_CLK_NS - 1) / `ANSS_CLK_NS)
`define ANSS_RD_CYC `ANSS_CEIL(`ANSS_T_AA_NS)
`define ANSS_PAGE_CYC `ANSS_CEIL(`ANSS_T_AAP_NS)
`define ANSS_PC_CYC `ANSS_CEIL(`ANSS_T_PC_NS)
`define ANSS_WP_CYC `ANSS_CEIL(`ANSS_T_WP_NS)
`define ANSS_CW_CYC `ANSS_CEIL(`ANSS_T_CW_NS)
`define ANSS_ZZL_CYC `ANSS_CEIL(`ANSS_T_ZZL_US * 1000)
`define ANSS_ZZEX_CYC `ANSS_CEIL(`ANSS_T_ZZEX_US * 1000)
`define ANSS_PU_CYC `ANSS_CEIL(`ANSS_T_PU_MS * 1000000)

`endif

// file: anss_pkg.sv
// Purpose: Types for the async memory host controller
// Assumes: Nothing beyond the map header
// Notes: States carry no fixed codes
package anss_pkg;
	typedef enum logic [3:0] {
		ANSS_PWRUP,
		ANSS_IDLE,
		ANSS_RD,
		ANSS_WR_SETUP,
		ANSS_WR_PULSE,
		ANSS_WR_HOLD,
		ANSS_OPEN,
		ANSS_PRECH,
		ANSS_SLEEP,
		ANSS_WAKE
	} anss_state_t;
endpackage

// file: anss_host.sv
// Purpose: Host controller driving a 64K x 16 async nonvolatile memory with sleep
// Assumes: One request at a time, held stable until req_ack
// Notes: Open row is kept for page accesses only when the next request is ready at once
// Notes on behaviour
// - Sleep is entered only from idle, after the last write has closed its row and waited the 3-cycle precharge.
// - After releasing sleep the host waits 450 us before the next access.
// - After power-up the host waits 1 ms before the first access.
// - Page writes pulse the write strobe again with only the column changed and chip low.
`timescale 1ns/1ns
`include "anss_map.svh"

module anss_host #(
	parameter int ADDR_W = 16,
	parameter int DATA_W = 16,
	parameter int CNT_W = 17,
	parameter int PWRUP_CYC = `ANSS_PU_CYC,
	parameter int ZZEX_CYC = `ANSS_ZZEX_CYC
)(
	input wire logic mclk,
	input wire logic resetn,
	input wire logic req_valid,
	input wire logic req_write,
	input wire logic [ADDR_W-1:0] req_addr,
	input wire logic [DATA_W-1:0] req_wdata,
	input wire logic [1:0] req_lane_en,
	input wire logic sleep_cmd,
	output logic req_ack,
	output logic rd_valid,
	output logic [DATA_W-1:0] rd_data,
	output logic awake,
	output logic mem_cs_n,
	output logic mem_we_n,
	output logic mem_oe_n,
	output logic mem_high_lane_sel_n,
	output logic mem_low_lane_sel_n,
	output logic mem_sleep_req_n,
	output logic [ADDR_W-1:0] mem_addr,
	output logic [DATA_W-1:0] mem_dq_out,
	output logic mem_dq_oe,
	input wire logic [DATA_W-1:0] mem_dq_in
);
	import anss_pkg::*;

	function automatic logic same_row(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] b);
		same_row = (a[ADDR_W-1:2] == b[ADDR_W-1:2]);
	endfunction

	// ==========================================================
	// Data pin synchroniser
	logic [DATA_W-1:0] dq_meta;
	logic [DATA_W-1:0] dq_sync;

	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
		begin
			dq_meta <= '0;
			dq_sync <= '0;
		end
		else
		begin
			dq_meta <= mem_dq_in;
			dq_sync <= dq_meta;
		end
	end

	// ==========================================================
	// Sequencer
	anss_state_t state, next_state;
	logic [CNT_W-1:0] cnt, next_cnt;
	logic page, next_page;
	logic next_req_ack, next_rd_valid, next_awake;
	logic [DATA_W-1:0] next_rd_data, next_dq_out;
	logic next_cs_n, next_we_n, next_oe_n, next_hi_n, next_lo_n, next_sleep_n, next_dq_oe;
	logic [ADDR_W-1:0] next_addr;
	logic take;

	always_comb
	begin
		next_state = state;
		next_cnt = (cnt != '0) ? cnt - CNT_W'(1) : cnt;
		next_page = page;
		next_req_ack = 1'h0;
		next_rd_valid = 1'h0;
		next_rd_data = rd_data;
		next_cs_n = mem_cs_n;
		next_we_n = mem_we_n;
		next_oe_n = mem_oe_n;
		next_hi_n = mem_high_lane_sel_n;
		next_lo_n = mem_low_lane_sel_n;
		next_sleep_n = mem_sleep_req_n;
		next_addr = mem_addr;
		next_dq_out = mem_dq_out;
		next_dq_oe = mem_dq_oe;
		take = 1'h0;
		case (state)
			ANSS_PWRUP:
			begin
				if (cnt == '0)
					next_state = ANSS_IDLE;
			end
			ANSS_IDLE:
			begin
				if (sleep_cmd)
				begin
					next_sleep_n = 1'h0;
					next_cnt = CNT_W'(`ANSS_ZZL_CYC - 1);
					next_state = ANSS_SLEEP;
				end
				else if (req_valid)
				begin
					take = 1'h1;
					next_page = 1'h0;
				end
			end
			ANSS_RD:
			begin
				if (cnt == '0)
				begin
					next_rd_data = dq_sync;
					next_rd_valid = 1'h1;
					next_state = ANSS_OPEN;
				end
			end
			ANSS_WR_SETUP:
			begin
				next_we_n = 1'h0;
				next_dq_oe = 1'h1;
				next_cnt = page ? CNT_W'(`ANSS_WP_CYC - 1) : CNT_W'(`ANSS_CW_CYC - 2);
				next_state = ANSS_WR_PULSE;
			end
			ANSS_WR_PULSE:
			begin
				if (cnt == '0)
				begin
					next_we_n = 1'h1;
					next_state = ANSS_WR_HOLD;
				end
			end
			ANSS_WR_HOLD:
			begin
				next_dq_oe = 1'h0;
				next_state = ANSS_OPEN;
			end
			ANSS_OPEN:
			begin
				if (req_valid && !sleep_cmd && same_row(req_addr, mem_addr))
				begin
					take = 1'h1;
					next_page = 1'h1;
				end
				else
				begin
					next_cs_n = 1'h1;
					next_oe_n = 1'h1;
					next_hi_n = 1'h1;
					next_lo_n = 1'h1;
					next_cnt = CNT_W'(`ANSS_PC_CYC - 1);
					next_state = ANSS_PRECH;
				end
			end
			ANSS_PRECH:
			begin
				if (cnt == '0)
					next_state = ANSS_IDLE;
			end
			ANSS_SLEEP:
			begin
				if (cnt == '0 && !sleep_cmd)
				begin
					next_sleep_n = 1'h1;
					next_cnt = CNT_W'(ZZEX_CYC - 1);
					next_state = ANSS_WAKE;
				end
			end
			ANSS_WAKE:
			begin
				if (cnt == '0)
					next_state = ANSS_IDLE;
			end
			default:
			begin
				next_state = ANSS_IDLE;
			end
		endcase
		if (take)
		begin
			next_req_ack = 1'h1;
			next_cs_n = 1'h0;
			next_addr = req_addr;
			next_dq_out = req_wdata;
			next_hi_n = !req_lane_en[1];
			next_lo_n = !req_lane_en[0];
			if (req_write)
			begin
				next_oe_n = 1'h1;
				next_state = ANSS_WR_SETUP;
			end
			else
			begin
				next_oe_n = 1'h0;
				// Page hit waits the column access, a new row the full access
				next_cnt = next_page ? CNT_W'(`ANSS_PAGE_CYC + `ANSS_SYNC_CYC)
					: CNT_W'(`ANSS_RD_CYC + `ANSS_SYNC_CYC);
				next_state = ANSS_RD;
			end
		end
		next_awake = (next_state != ANSS_PWRUP) && (next_state != ANSS_SLEEP)
			&& (next_state != ANSS_WAKE);
	end

	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
		begin
			state <= ANSS_PWRUP;
			cnt <= CNT_W'(PWRUP_CYC - 1);
			page <= 1'h0;
			req_ack <= 1'h0;
			rd_valid <= 1'h0;
			rd_data <= '0;
			awake <= 1'h0;
			mem_cs_n <= 1'h1;
			mem_we_n <= 1'h1;
			mem_oe_n <= 1'h1;
			mem_high_lane_sel_n <= 1'h1;
			mem_low_lane_sel_n <= 1'h1;
			mem_sleep_req_n <= 1'h1;
			mem_addr <= '0;
			mem_dq_out <= '0;
			mem_dq_oe <= 1'h0;
		end
		else
		begin
			state <= next_state;
			cnt <= next_cnt;
			page <= next_page;
			req_ack <= next_req_ack;
			rd_valid <= next_rd_valid;
			rd_data <= next_rd_data;
			awake <= next_awake;
			mem_cs_n <= next_cs_n;
			mem_we_n <= next_we_n;
			mem_oe_n <= next_oe_n;
			mem_high_lane_sel_n <= next_hi_n;
			mem_low_lane_sel_n <= next_lo_n;
			mem_sleep_req_n <= next_sleep_n;
			mem_addr <= next_addr;
			mem_dq_out <= next_dq_out;
			mem_dq_oe <= next_dq_oe;
		end
	end

	// ==========================================================
	// Checks
	logic [CNT_W-1:0] pu_cnt;
	logic [CNT_W-1:0] zz_cnt;
	logic [CNT_W-1:0] zl_cnt;

	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
		begin
			pu_cnt <= '0;
			zz_cnt <= '1;
			zl_cnt <= '0;
		end
		else
		begin
			pu_cnt <= (pu_cnt != '1) ? pu_cnt + CNT_W'(1) : pu_cnt;
			zz_cnt <= !mem_sleep_req_n ? '0 : ((zz_cnt != '1) ? zz_cnt + CNT_W'(1) : zz_cnt);
			zl_cnt <= mem_sleep_req_n ? '0 : ((zl_cnt != '1) ? zl_cnt + CNT_W'(1) : zl_cnt);
		end
	end

	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!resetn);

	property p_pwrup_gap;
		!mem_cs_n |-> pu_cnt >= CNT_W'(PWRUP_CYC);
	endproperty
	a_pwrup_gap: assert property (p_pwrup_gap) else $error("access during power-up");

	property p_wake_gap;
		$fell(mem_cs_n) |-> zz_cnt >= CNT_W'(ZZEX_CYC);
	endproperty
	a_wake_gap: assert property (p_wake_gap) else $error("access before wake-up wait");

	// Row at the new strobe must match the row held in the open cycle before the take
	property p_page_row;
		$fell(mem_we_n) && !$past(mem_cs_n, 2) && !mem_cs_n
			|-> same_row(mem_addr, $past(mem_addr, 2));
	endproperty
	a_page_row: assert property (p_page_row) else $error("row moved in page write");

	property p_page_data;
		$rose(mem_we_n) |-> !mem_cs_n && mem_dq_oe && $stable(mem_dq_out);
	endproperty
	a_page_data: assert property (p_page_data) else $error("write data not held");

	property p_sleep_quiet;
		!mem_sleep_req_n |-> mem_cs_n && !mem_dq_oe && mem_we_n;
	endproperty
	a_sleep_quiet: assert property (p_sleep_quiet) else $error("bus active in sleep");

	property p_sleep_min;
		$rose(mem_sleep_req_n) |-> zl_cnt >= CNT_W'(`ANSS_ZZL_CYC);
	endproperty
	a_sleep_min: assert property (p_sleep_min) else $error("sleep low too short");

	property p_we_pulse;
		$fell(mem_we_n) |-> !mem_we_n [*2] ##0 (mem_oe_n && mem_dq_oe);
	endproperty
	a_we_pulse: assert property (p_we_pulse) else $error("short write pulse");

	property p_ack_once;
		req_ack |=> !req_ack;
	endproperty
	a_ack_once: assert property (p_ack_once) else $error("request acknowledged twice");

	c_rand_read: cover property (rd_valid && !page);
	c_page_read: cover property (rd_valid && page);
	c_page_write: cover property ($rose(mem_we_n) && page);
	c_sleep_wake: cover property ($rose(mem_sleep_req_n) ##[1:10] !mem_sleep_req_n == 1'h0);
endmodule

// file: anss_mem_model.sv
// Purpose: Behavioural model of the sleep-capable async memory
// Assumes: Device is powered from time zero
// Notes: Released bytes show the inverse of the word at the current address
`timescale 1ns/1ns
module anss_mem_model #(
	parameter int ACC_NS = 25,
	parameter int PU_NS = 2000,
	parameter int WAKE_NS = 1000
)(
	input wire logic cs_n,
	input wire logic we_n,
	input wire logic oe_n,
	input wire logic [1:0] lane_n,
	input wire logic sleep_n,
	input wire logic [15:0] addr,
	input wire logic [15:0] hq,
	input wire logic hq_oe,
	output logic [15:0] bus,
	output int err
);
	logic [15:0] mem [0:65535];
	logic [15:0] rd;
	logic armed = 1'b0;
	logic en_now;
	logic en_dly;
	logic drv;
	realtime t_wake = 0;
	initial err = 0;
	// ====================
	// Read drive
	assign en_now = sleep_n && !cs_n && !oe_n && we_n;
	assign #6 en_dly = en_now;
	assign drv = en_now && en_dly;
	assign #(ACC_NS) rd = mem[addr];
	always_comb
	begin
		for (int i = 0; i < 2; i++)
		begin
			if (hq_oe)
				bus[i*8+:8] = (drv && !lane_n[i]) ? 8'hxx : hq[i*8+:8];
			else
				bus[i*8+:8] = (drv && !lane_n[i]) ? rd[i*8+:8] : ~rd[i*8+:8];
		end
	end
	// ====================
	// Writes
	always @(negedge we_n)
		armed = sleep_n && !cs_n;
	always @(posedge we_n or posedge cs_n)
	begin
		if (armed && sleep_n)
		begin
			for (int i = 0; i < 2; i++)
				if (!lane_n[i])
					mem[addr][i*8+:8] = bus[i*8+:8];
		end
		armed = 1'b0;
	end
	// ====================
	// Host timing checks
	always @(posedge sleep_n)
		t_wake = $realtime;
	always @(negedge cs_n)
		if (!sleep_n || $realtime < PU_NS || $realtime - t_wake < WAKE_NS)
			err++;
endmodule

// file: test_async_nv_sram_access_sleep.sv
// Purpose: Self-checking bench for the async memory host
// Assumes: Shortened power-up and wake counts
// Notes: Inputs change 1 ns after the rising edge
`timescale 1ns/1ns
module test_async_nv_sram_access_sleep;
	localparam int PU = 200;
	localparam int ZZ = 100;
	logic mclk = 0;
	logic resetn = 0;
	logic req_valid = 0;
	logic req_write = 0;
	logic [15:0] req_addr = '0;
	logic [15:0] req_wdata = '0;
	logic [1:0] req_lane_en = '0;
	logic sleep_cmd = 0;
	logic req_ack, rd_valid, awake, cs_n, we_n, oe_n, hs_n, ls_n, zz_n, dq_oe;
	logic [15:0] rd_data, addr, dq_out, bus;
	int err, error_cnt = 0, compares = 0, cyc = 0, cs_up = 0, acks = 0, t_up = 0, t_dn = 0;
	int l1, l2, c0, a0, t_rel;
	anss_host #(.PWRUP_CYC(PU), .ZZEX_CYC(ZZ)) i_anss_host (.mclk(mclk), .resetn(resetn),
		.req_valid(req_valid), .req_write(req_write), .req_addr(req_addr),
		.req_wdata(req_wdata), .req_lane_en(req_lane_en), .sleep_cmd(sleep_cmd),
		.req_ack(req_ack), .rd_valid(rd_valid), .rd_data(rd_data), .awake(awake),
		.mem_cs_n(cs_n), .mem_we_n(we_n), .mem_oe_n(oe_n), .mem_high_lane_sel_n(hs_n),
		.mem_low_lane_sel_n(ls_n), .mem_sleep_req_n(zz_n), .mem_addr(addr),
		.mem_dq_out(dq_out), .mem_dq_oe(dq_oe), .mem_dq_in(bus));
	anss_mem_model #(.PU_NS(PU * 10), .WAKE_NS(ZZ * 10)) i_anss_mem_model (.cs_n(cs_n),
		.we_n(we_n), .oe_n(oe_n), .lane_n({hs_n, ls_n}), .sleep_n(zz_n), .addr(addr),
		.hq(dq_out), .hq_oe(dq_oe), .bus(bus), .err(err));
	// ====================
	// Clock, monitors, watchdog
	initial
		forever #5 mclk = ~mclk;
	always @(posedge mclk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			error_cnt++;
			report_and_stop();
		end
	end
	always @(negedge mclk)
		if (req_ack === 1'b1)
			acks++;
	always @(posedge cs_n)
		cs_up++;
	always @(posedge zz_n)
		t_up = cyc;
	always @(negedge cs_n)
		t_dn = cyc;
	// ====================
	// Shared tasks
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic req(input logic w, input logic [15:0] a, input logic [15:0] d,
		input logic [1:0] ln, output int lat);
		int n;
		req_valid = 1;
		req_write = w;
		req_addr = a;
		req_wdata = d;
		req_lane_en = ln;
		n = 0;
		do
		begin
			@(posedge mclk);
			#1;
			n++;
		end
		while (req_ack !== 1'b1 && n < 3000);
		chk("request taken", req_ack, 1);
		lat = 0;
		do
		begin
			@(posedge mclk);
			#1;
			lat++;
		end
		while (!w && rd_valid !== 1'b1 && lat < 40);
	endtask
	task automatic rd(input logic [15:0] a, input logic [15:0] exp, output int lat);
		req(0, a, 16'h0000, 2'b11, lat);
		chk("read valid", rd_valid, 1);
		chk("read data", rd_data, exp);
	endtask
	task automatic settle();
		int n;
		req_valid = 0;
		n = 0;
		while (cs_n !== 1'b1 && n < 50)
		begin
			@(posedge mclk);
			#1;
			n++;
		end
		chk("chip select idle", cs_n, 1);
	endtask
	task automatic report_and_stop();
		$display("Checks %0d mismatches %0d", compares, error_cnt);
		if (error_cnt == 0 && compares > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	// ====================
	// Scenarios
	task automatic t_powerup();
		req(1, 16'h0004, 16'h1234, 2'b11, l1);
		chk("first access wait", t_dn - t_rel >= PU, 1);
		settle();
		rd(16'h0004, 16'h1234, l1);
		req(1, 16'h8007, 16'hbeef, 2'b11, l1);
		settle();
		rd(16'h8007, 16'hbeef, l1);
		settle();
		$display("test powerup and rw done");
	endtask
	task automatic t_lanes();
		req(1, 16'h0010, 16'haaaa, 2'b11, l1);
		settle();
		req(1, 16'h0010, 16'h5555, 2'b10, l1);
		settle();
		req(1, 16'h0010, 16'h3c3c, 2'b01, l1);
		settle();
		rd(16'h0010, 16'h553c, l1);
		settle();
		$display("test lanes done");
	endtask
	task automatic t_page();
		c0 = cs_up;
		req(1, 16'h0022, 16'h1002, 2'b11, l1);
		req(1, 16'h0020, 16'h1000, 2'b11, l1);
		req(1, 16'h0023, 16'h1003, 2'b11, l1);
		req(1, 16'h0021, 16'h1001, 2'b11, l1);
		settle();
		rd(16'h0023, 16'h1003, l1);
		rd(16'h0020, 16'h1000, l2);
		rd(16'h0022, 16'h1002, l2);
		rd(16'h0021, 16'h1001, l2);
		settle();
		chk("chip select rises", cs_up - c0, 2);
		chk("page faster", l2 < l1, 1);
		$display("test page done");
	endtask
	task automatic t_sleep();
		req(1, 16'h0030, 16'hcafe, 2'b11, l1);
		req_valid = 0;
		sleep_cmd = 1;
		@(posedge mclk);
		#1;
		req_valid = 1;
		req_write = 0;
		a0 = acks;
		repeat (150) @(posedge mclk);
		#1;
		chk("sleep pin", zz_n, 0);
		chk("awake", awake, 0);
		chk("acks in sleep", acks - a0, 0);
		sleep_cmd = 0;
		rd(16'h0030, 16'hcafe, l1);
		chk("wake wait", t_dn - t_up >= ZZ, 1);
		chk("awake after wake", awake, 1);
		settle();
		chk("model timing errors", err, 0);
		$display("test sleep done");
	endtask
	initial
	begin
		repeat (6) @(posedge mclk);
		#1;
		chk("reset cs", cs_n, 1);
		chk("reset dq oe", dq_oe, 0);
		resetn = 1;
		t_rel = cyc;
		t_powerup();
		t_lanes();
		t_page();
		t_sleep();
		report_and_stop();
	end
endmodule
